// ==== hw/mon_trim_pkg.sv ====
// Constants for the analog monitor trim block: register map, field layout,
// reset values, trim limits and timing counts.
// Assumes a 50 MHz APB clock; every other file but the keypad panel model imports this package whole.
package mon_trim_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int DONE_TIME_MS = 1000;
    localparam int DONE_CYCLES = (CLK_HZ / 1000) * DONE_TIME_MS;

    // Register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_KEY = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_OFFSET = 12'h00C;
    localparam logic [11:0] OFS_GAIN = 12'h010;
    localparam logic [11:0] OFS_RAW0 = 12'h014;
    localparam logic [11:0] OFS_RAW1 = 12'h018;
    localparam logic [11:0] OFS_DAC = 12'h01C;

    // CTRL fields
    localparam int CTRL_WP_LSB = 0;
    localparam int CTRL_WP_W = 16;
    localparam int CTRL_INIT_BIT = 16;
    localparam logic [15:0] WP_PERMIT = 16'h0000;
    localparam logic [15:0] WP_RESET = 16'h0000;

    // KEY register: one bit per key, a write of 1 is a key press
    localparam int KEY_UP = 0;
    localparam int KEY_DOWN = 1;
    localparam int KEY_SCROLL = 2;
    localparam int KEY_DATA = 3;
    localparam int KEY_MODE = 4;
    localparam int KEY_ENTER_OFS = 5;
    localparam int KEY_ENTER_GAIN = 6;

    // STATUS fields
    localparam int ST_SCREEN_LSB = 0;
    localparam int ST_CHAN_BIT = 2;
    localparam int ST_DONE_BIT = 3;
    localparam int ST_REFUSED_BIT = 4;
    localparam int ST_MENU_BIT = 5;

    // Trim codes: 8-bit signed, gain limited to +/-125 (50..150 %)
    localparam int TRIM_W = 8;
    localparam logic signed [7:0] OFS_MAX = 8'sh7F;
    localparam logic signed [7:0] OFS_MIN = -8'sh7F;
    localparam logic signed [7:0] GAIN_MAX = 8'sh7D;
    localparam logic signed [7:0] GAIN_MIN = -8'sh7D;
    localparam logic signed [7:0] OFS0_RESET = -8'sh02;
    localparam logic signed [7:0] OFS1_RESET = 8'sh01;
    localparam logic signed [7:0] GAIN_RESET = 8'sh00;
    // Gain: output = raw * (250 + code) / 250, 0.4 % per step
    localparam int GAIN_UNITY = 250;

    typedef enum logic [1:0] {
        SCR_MENU = 2'b00,
        SCR_OFFSET = 2'b01,
        SCR_GAIN = 2'b10
    } screen_t;
endpackage

// ==== hw/trim_store.sv ====
// Nonvolatile trim store: four 8-bit entries, offsets then gains per channel.
// Written only on confirm; never touched by parameter initialisation.
module trim_store
    import mon_trim_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [4*TRIM_W-1:0] wr_data,
    output logic [4*TRIM_W-1:0] rd_data
);
    logic [4*TRIM_W-1:0] mem_r;

    // Reset stands for the shipped calibration image
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_r <= {GAIN_RESET, GAIN_RESET, OFS1_RESET, OFS0_RESET};
        end else if (wr_en) begin
            mem_r <= wr_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= {GAIN_RESET, GAIN_RESET, OFS1_RESET, OFS0_RESET};
        end else begin
            rd_data <= mem_r;
        end
    end
endmodule

// ==== hw/mon_scale.sv ====
// Monitor converter code for one channel: raw scaled by gain, plus offset.
// Raw input is a 16-bit signed value from logic on the same clock.
module mon_scale
    import mon_trim_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic signed [15:0] raw,
    input wire logic signed [TRIM_W-1:0] gain_code,
    input wire logic signed [TRIM_W-1:0] ofs_code,
    output logic signed [15:0] dac_code
);
    logic signed [26:0] prod;
    logic signed [26:0] scaled;
    logic signed [26:0] sum;

    always_comb begin
        // Widen both factors first so the product never wraps at 16 bits
        prod = 27'(raw) * 27'(10'(GAIN_UNITY) + 10'(gain_code));
        scaled = prod / 27'sd250;
        sum = scaled + 27'(ofs_code);
    end

    // Saturate to the converter range
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_code <= 16'sh0000;
        end else if (sum > 27'sd32767) begin
            dac_code <= 16'sh7FFF;
        end else if (sum < -27'sd32768) begin
            dac_code <= -16'sh8000;
        end else begin
            dac_code <= sum[15:0];
        end
    end
endmodule

// ==== hw/analog_monitor_trim.sv ====
// Analog monitor trim: keypad-driven offset and gain trim for two monitor
// channels, reached over APB. Keypad presses arrive as writes to KEY.
// Assumes raw monitor values are synchronous to pclk.
// Notes on behaviour
// RULE1: Signed offset code per channel, 18.9 mV step
// RULE2: Signed gain code, 0.4 % step, 50-150 %
// RULE3: Edits refused unless write protect permits
// RULE4: Parameter init leaves trims untouched
// RULE5: Independent trims for torque and speed channels
// RULE6: Up/down steps selected channel by one
// RULE7: Scroll moves selection to second channel
// RULE8: Data key stores, shows done one second
// RULE9: Mode/set key returns to main menu
// RULE10: Offsets start from factory calibration
// RULE11: Converter code is gain-scaled raw plus offset
module analog_monitor_trim
    import mon_trim_pkg::*;
#(
    parameter int DONE_COUNT = DONE_CYCLES
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic signed [15:0] torque_raw,
    input wire logic signed [15:0] speed_raw,
    output logic signed [15:0] torque_dac,
    output logic signed [15:0] speed_dac,
    output logic done_status,
    output logic param_init_pulse
);
    logic [15:0] write_protect_setting_r;
    screen_t screen_r;
    logic chan_r;
    logic signed [TRIM_W-1:0] ofs_r [2];
    logic signed [TRIM_W-1:0] gain_r [2];
    logic [25:0] done_cnt_r;
    logic refused_r;
    logic [4*TRIM_W-1:0] nv_rd;
    logic nv_wr;
    logic loaded_r;
    logic signed [15:0] dac_w [2];
    logic signed [15:0] raw_w [2];

    logic wr_acc;
    logic rd_acc;
    logic addr_ok;
    logic [6:0] keys;
    logic permit;
    logic editing;

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;
    assign keys = (wr_acc && paddr == OFS_KEY) ? pwdata[6:0] : 7'h00;
    assign permit = write_protect_setting_r == WP_PERMIT;
    assign editing = screen_r != SCR_MENU;
    assign nv_wr = editing && keys[KEY_DATA];
    assign raw_w[0] = torque_raw;
    assign raw_w[1] = speed_raw;

    always_comb begin
        case (paddr)
            OFS_CTRL, OFS_KEY, OFS_STATUS, OFS_OFFSET, OFS_GAIN,
            OFS_RAW0, OFS_RAW1, OFS_DAC: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // Zero-wait APB: every access completes in its first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_protect_setting_r <= WP_RESET;
        end else if (wr_acc && paddr == OFS_CTRL) begin
            write_protect_setting_r <= pwdata[CTRL_WP_LSB +: CTRL_WP_W];
        end
    end

    // Init clears ordinary parameters elsewhere; trims are not wired to it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            param_init_pulse <= 1'b0;
        end else begin
            param_init_pulse <= wr_acc && paddr == OFS_CTRL && permit
                && pwdata[CTRL_INIT_BIT]; // RULE4
        end
    end

    // Menu navigation: enter a trim screen, leave with mode/set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            screen_r <= SCR_MENU;
            chan_r <= 1'b0;
        end else begin
            case (screen_r)
                SCR_MENU: begin
                    chan_r <= 1'b0;
                    if (keys[KEY_ENTER_OFS]) begin
                        screen_r <= SCR_OFFSET;
                    end else if (keys[KEY_ENTER_GAIN]) begin
                        screen_r <= SCR_GAIN;
                    end
                end
                SCR_OFFSET, SCR_GAIN: begin
                    if (keys[KEY_MODE]) begin
                        screen_r <= SCR_MENU; // RULE9
                    end else if (keys[KEY_SCROLL]) begin
                        chan_r <= 1'b1; // RULE7
                    end
                end
                default: screen_r <= SCR_MENU;
            endcase
        end
    end

    // Working trims: loaded from the store once after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loaded_r <= 1'b0;
        end else begin
            loaded_r <= 1'b1;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            logic sel;
            assign sel = editing && permit && chan_r == 1'(ch);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ofs_r[ch] <= (ch == 0) ? OFS0_RESET : OFS1_RESET; // RULE10
                    gain_r[ch] <= GAIN_RESET;
                end else if (!loaded_r) begin
                    ofs_r[ch] <= nv_rd[ch*TRIM_W +: TRIM_W];
                    gain_r[ch] <= nv_rd[(ch+2)*TRIM_W +: TRIM_W];
                end else if (sel && screen_r == SCR_OFFSET) begin // RULE3 RULE5
                    if (keys[KEY_UP] && ofs_r[ch] < OFS_MAX) begin
                        ofs_r[ch] <= ofs_r[ch] + 8'sd1; // RULE1 RULE6
                    end else if (keys[KEY_DOWN] && ofs_r[ch] > OFS_MIN) begin
                        ofs_r[ch] <= ofs_r[ch] - 8'sd1; // RULE6
                    end
                end else if (sel && screen_r == SCR_GAIN) begin // RULE3
                    if (keys[KEY_UP] && gain_r[ch] < GAIN_MAX) begin
                        gain_r[ch] <= gain_r[ch] + 8'sd1; // RULE2 RULE6
                    end else if (keys[KEY_DOWN] && gain_r[ch] > GAIN_MIN) begin
                        gain_r[ch] <= gain_r[ch] - 8'sd1; // RULE2
                    end
                end
            end

            mon_scale u_scale (
                .pclk(pclk),
                .presetn(presetn),
                .raw(raw_w[ch]),
                .gain_code(gain_r[ch]),
                .ofs_code(ofs_r[ch]),
                .dac_code(dac_w[ch])
            ); // RULE11
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            torque_dac <= 16'sh0000;
            speed_dac <= 16'sh0000;
        end else begin
            torque_dac <= dac_w[0];
            speed_dac <= dac_w[1];
        end
    end

    trim_store u_store (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(nv_wr),
        .wr_data({gain_r[1], gain_r[0], ofs_r[1], ofs_r[0]}),
        .rd_data(nv_rd)
    ); // RULE8

    // Completion status stands one second, then the idle status returns
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_cnt_r <= 26'h000_0000;
            done_status <= 1'b0;
        end else if (nv_wr) begin
            done_cnt_r <= 26'(DONE_COUNT - 1);
            done_status <= 1'b1; // RULE8
        end else if (done_cnt_r != 26'h000_0000) begin
            done_cnt_r <= done_cnt_r - 26'h000_0001;
        end else begin
            done_status <= 1'b0;
        end
    end

    // Sticky flag for a refused edit; set wins over a clearing status read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refused_r <= 1'b0;
        end else if (editing && !permit && (keys[KEY_UP] || keys[KEY_DOWN])) begin
            refused_r <= 1'b1; // RULE3
        end else if (rd_acc && paddr == OFS_STATUS) begin
            refused_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_acc) begin
            case (paddr)
                OFS_CTRL: prdata <= {16'h0000, write_protect_setting_r};
                OFS_STATUS: prdata <= {26'h000_0000, !editing, refused_r, done_status,
                    chan_r, screen_r};
                OFS_OFFSET: prdata <= {16'h0000, ofs_r[1], ofs_r[0]};
                OFS_GAIN: prdata <= {16'h0000, gain_r[1], gain_r[0]};
                OFS_RAW0: prdata <= {16'h0000, torque_raw};
                OFS_RAW1: prdata <= {16'h0000, speed_raw};
                OFS_DAC: prdata <= {speed_dac, torque_dac};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// ==== sim/mon_trim_properties.sv ====
// Checker for the monitor trim block, bound to its top module.
// Assumes APB with one access cycle per transfer.
module mon_trim_properties
    import mon_trim_pkg::*;
#(
    parameter int DONE_COUNT = 20
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic done_status,
    input wire logic param_init_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic acc_wr;
    logic data_wr;
    logic init_wr;
    logic [31:0] done_cnt_r;
    logic [31:0] done_cnt_nxt;
    assign acc_wr = psel && penable && pwrite;
    assign data_wr = acc_wr && paddr == OFS_KEY && pwdata[KEY_DATA];
    assign init_wr = acc_wr && paddr == OFS_CTRL && pwdata[CTRL_INIT_BIT];
    // Cycles spent in the completion status so far
    assign done_cnt_nxt = done_status ? done_cnt_r + 32'h0000_0001 : 32'h0000_0000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_cnt_r <= 32'h0000_0000;
        end else begin
            done_cnt_r <= done_cnt_nxt;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_READY_SETUP:
        assert property (psel && !penable |=> pready) else $error("no ready after setup");
    AST_READY_ONE:
        assert property (pready |=> !pready) else $error("ready longer than one cycle");
    AST_ERR_READY:
        assert property (pslverr |-> pready) else $error("error without ready");
    AST_UNMAPPED:
        assert property (psel && !penable && paddr > OFS_DAC |=> pslverr)
        else $error("unmapped address not refused");
    AST_MAPPED:
        assert property (psel && !penable && paddr <= OFS_DAC && paddr[1:0] == 2'b00
            |=> !pslverr) else $error("mapped address refused");
    AST_DONE_CAUSE:
        assert property ($rose(done_status) |-> $past(data_wr) || $past(data_wr, 2)
            || $past(data_wr, 3)) else $error("completion without confirm");
    AST_DONE_LEN:
        assert property ($fell(done_status) |-> done_cnt_r == DONE_COUNT)
        else $error("completion length wrong");
    AST_DONE_MAX:
        assert property (done_cnt_r <= DONE_COUNT) else $error("completion too long");
    AST_INIT_CAUSE:
        assert property (param_init_pulse |-> $past(init_wr) || $past(init_wr, 2))
        else $error("init pulse without request");
    AST_INIT_ONE:
        assert property (param_init_pulse |=> !param_init_pulse) else $error("init pulse long");
endmodule

bind analog_monitor_trim mon_trim_properties #(.DONE_COUNT(DONE_COUNT)) props_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .done_status(done_status), .param_init_pulse(param_init_pulse));

// ==== sim/keypad_panel.sv ====
// Keypad panel model: each press or query is one APB transfer.
// Assumes the caller invokes xfer from one process only.
module keypad_panel (
    input wire logic pclk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench timeout may end a wait for the answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data no longer shows the last value
        pwdata <= ~d;
    endtask
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the monitor trim block.
// Assumes a shortened completion count of 20 cycles.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import mon_trim_pkg::*;
    localparam int DC = 20;
    typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic done_status, param_init_pulse, seen_init;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic signed [15:0] torque_raw, speed_raw, torque_dac, speed_dac;
    int n_errors, samples_checked, cyc, k, n;
    row_t rows[11];
    analog_monitor_trim #(.DONE_COUNT(DC)) analog_monitor_trim_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .torque_raw(torque_raw), .speed_raw(speed_raw), .torque_dac(torque_dac),
        .speed_dac(speed_dac), .done_status(done_status), .param_init_pulse(param_init_pulse));
    keypad_panel keypad_panel_i (.pclk(pclk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata));
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            n_errors++;
            $display("wrong value at %0t ns: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        keypad_panel_i.xfer(w, a, d, q, e);
    endtask
    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (param_init_pulse === 1'b1)
            seen_init <= 1'b1;
        // Far above the 130 or so cycles the sequence needs
        if (cyc == 3000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        {presetn, seen_init, n_errors, samples_checked, cyc} = '0;
        torque_raw = 16'sh0000;
        speed_raw = 16'sh0000;
        rows = '{
            '{1'b0, OFS_OFFSET, 32'h0000_0000, 32'h0000_01FE, 1'b0},
            '{1'b0, OFS_GAIN, 32'h0000_0000, 32'h0000_0000, 1'b0},
            '{1'b0, OFS_STATUS, 32'h0000_0000, 32'h0000_0020, 1'b0},
            '{1'b0, 12'h020, 32'h0000_0000, 32'h0000_0000, 1'b1},
            '{1'b1, OFS_KEY, 32'h0000_0020, 32'h0000_0000, 1'b0},
            '{1'b1, OFS_KEY, 32'h0000_0001, 32'h0000_0000, 1'b0},
            '{1'b0, OFS_OFFSET, 32'h0000_0000, 32'h0000_01FF, 1'b0},
            '{1'b1, OFS_KEY, 32'h0000_0004, 32'h0000_0000, 1'b0},
            '{1'b1, OFS_KEY, 32'h0000_0002, 32'h0000_0000, 1'b0},
            '{1'b0, OFS_OFFSET, 32'h0000_0000, 32'h0000_00FF, 1'b0},
            '{1'b0, OFS_STATUS, 32'h0000_0000, 32'h0000_0005, 1'b0}};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            chk(e, rows[i].e);
            if (!rows[i].w)
                chk(q, rows[i].x);
        end
        bus(1'b1, OFS_KEY, 32'h0000_0008);
        n = 0;
        while (done_status !== 1'b1 && n < 10) begin
            @(posedge pclk);
            n++;
        end
        k = 0;
        while (done_status === 1'b1 && k < 100) begin
            @(posedge pclk);
            k++;
        end
        chk(k, DC);
        bus(1'b1, OFS_KEY, 32'h0000_0010);
        bus(1'b0, OFS_STATUS, 32'h0000_0000);
        chk(q, 32'h0000_0020);
        // Protected: init request and gain edit are both refused
        bus(1'b1, OFS_CTRL, 32'h0000_0001);
        bus(1'b1, OFS_CTRL, 32'h0001_0001);
        chk(seen_init, 1'b0);
        bus(1'b1, OFS_KEY, 32'h0000_0040);
        bus(1'b1, OFS_KEY, 32'h0000_0001);
        bus(1'b0, OFS_GAIN, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        bus(1'b0, OFS_STATUS, 32'h0000_0000);
        chk(q, 32'h0000_0012);
        bus(1'b1, OFS_CTRL, 32'h0000_0000);
        repeat (3) bus(1'b1, OFS_KEY, 32'h0000_0001);
        bus(1'b1, OFS_CTRL, 32'h0001_0000);
        repeat (3) @(posedge pclk);
        chk(seen_init, 1'b1);
        bus(1'b0, OFS_OFFSET, 32'h0000_0000);
        chk(q, 32'h0000_00FF);
        bus(1'b0, OFS_GAIN, 32'h0000_0000);
        chk(q, 32'h0000_0003);
        torque_raw <= 16'sd1000;
        speed_raw <= -16'sd500;
        repeat (5) @(posedge pclk);
        chk({16'h0000, torque_dac}, 32'h0000_03F3);
        chk({16'h0000, speed_dac}, 32'h0000_FE0C);
        bus(1'b0, OFS_DAC, 32'h0000_0000);
        chk(q, 32'hFE0C_03F3);
        // Mid-run reset: outputs clear, trims come back at the shipped calibration
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({28'h000_0000, pready, pslverr, done_status, param_init_pulse},
            32'h0000_0000);
        chk({speed_dac, torque_dac}, 32'h0000_0000);
        presetn <= 1'b1;
        @(posedge pclk);
        bus(1'b0, OFS_OFFSET, 32'h0000_0000);
        chk(q, 32'h0000_01FE);
        repeat (5) @(posedge pclk);
        bus(1'b0, OFS_DAC, 32'h0000_0000);
        chk(q, 32'hFE0D_03E6);
        final_report();
    end
endmodule
